// >>> include/csf_pkg.sv
// Constants shared by the status flag block and its flag unit.
package csf_pkg;

  // Register bus geometry.
  localparam int CSF_ADDR_W = 4;
  localparam int CSF_DATA_W = 16;

  // Word offsets on the register port.
  localparam logic [3:0] CSF_OFS_STATUS = 4'h0;
  localparam logic [3:0] CSF_OFS_CORE_CTRL = 4'h1;
  localparam logic [3:0] CSF_OFS_INT_CTRL = 4'h2;

  // Field positions in cpu_status_word.
  localparam int CSF_BIT_SAT_A = 13;
  localparam int CSF_BIT_SAT_B = 12;
  localparam int CSF_BIT_SAT_ANY = 10;
  localparam int CSF_BIT_PRIO_HI = 7;
  localparam int CSF_BIT_PRIO_LO = 5;
  localparam int CSF_BIT_LOOP = 4;
  localparam int CSF_BIT_NEG = 3;
  localparam int CSF_BIT_OVF = 2;
  localparam int CSF_BIT_ZERO = 1;
  localparam int CSF_BIT_CARRY = 0;

  // Field positions in the control registers.
  localparam int CSF_BIT_PRIO_TOP = 3;
  localparam int CSF_BIT_NEST_DIS = 15;

  // Number of ALU flags and the level that masks user interrupts.
  localparam int CSF_NFLAGS = 4;
  localparam logic [2:0] CSF_PRIO_MASK_ALL = 3'h7;

  // Reset values.
  localparam logic [2:0] CSF_RST_PRIO_LOW = 3'h0;
  localparam logic CSF_RST_PRIO_TOP = 1'b0;
  localparam logic CSF_RST_NEST_DIS = 1'b0;
  localparam logic [3:0] CSF_RST_FLAGS = 4'h0;
  localparam logic CSF_RST_SAT = 1'b0;
  localparam logic CSF_RST_LOOP = 1'b0;
  localparam logic [15:0] CSF_RST_RDATA = 16'h0000;

endpackage

// >>> include/csf_alu_if.sv
// Signals between the status block and its ALU flag unit.
`timescale 1ns/1ps
`default_nettype none
interface csf_alu_if;
  import csf_pkg::*;
  logic upd;
  logic [CSF_NFLAGS-1:0] aff;
  logic neg;
  logic ovf;
  logic zero;
  logic carry;
  logic z_chain;
  logic sw_we;
  logic [CSF_NFLAGS-1:0] sw_flags;
  logic [CSF_NFLAGS-1:0] flags;
  modport unit (
    input upd, aff, neg, ovf, zero, carry, z_chain, sw_we, sw_flags,
    output flags
  );
  modport core (
    output upd, aff, neg, ovf, zero, carry, z_chain, sw_we, sw_flags,
    input flags
  );
endinterface
`default_nettype wire

// >>> hw/csf_alu_flags.sv
// ALU negative, overflow, zero and carry flags of the status word.
`timescale 1ns/1ps
`default_nettype none
module csf_alu_flags (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  csf_alu_if.unit alu
);
  import csf_pkg::*;

  logic [CSF_NFLAGS-1:0] flags_r;
  logic [CSF_NFLAGS-1:0] flags_nxt;
  logic [CSF_NFLAGS-1:0] result_v;
  logic z_new;

  ////////////////////////////////////////////////////////////////////////////
  // A chained operation may only clear zero, so a multi-word result reads
  // zero only when every word was zero.
  assign z_new = alu.z_chain ? (flags_r[CSF_BIT_ZERO] & alu.zero) : alu.zero;

  always_comb begin
    result_v = flags_r;
    result_v[CSF_BIT_NEG] = alu.neg;
    result_v[CSF_BIT_OVF] = alu.ovf;
    result_v[CSF_BIT_ZERO] = z_new;
    result_v[CSF_BIT_CARRY] = alu.carry;
  end

  // An instruction update wins over a software write in the same cycle for the flags in its affect mask.
  genvar gi;
  generate
    for (gi = 0; gi < CSF_NFLAGS; gi++) begin : g_flag
      assign flags_nxt[gi] = (alu.upd && alu.aff[gi]) ? result_v[gi] :
                             alu.sw_we ? alu.sw_flags[gi] :
                             flags_r[gi];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flags_r <= CSF_RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign alu.flags = flags_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_neg_follows: assert property (
    alu.upd && alu.aff[CSF_BIT_NEG] |=> flags_r[CSF_BIT_NEG] == $past(alu.neg))
    else $error("negative flag did not follow the result");
  a_ovf_follows: assert property (
    alu.upd && alu.aff[CSF_BIT_OVF] |=> flags_r[CSF_BIT_OVF] == $past(alu.ovf))
    else $error("overflow flag did not follow the result");
  a_zero_clears: assert property (
    alu.upd && alu.aff[CSF_BIT_ZERO] && !alu.zero |=> !flags_r[CSF_BIT_ZERO])
    else $error("zero flag not cleared by a non-zero result");
  a_carry_follows: assert property (
    alu.upd && alu.aff[CSF_BIT_CARRY]
    |=> flags_r[CSF_BIT_CARRY] == $past(alu.carry))
    else $error("carry flag did not follow the carry out");
  a_flags_hold: assert property (
    !alu.upd && !alu.sw_we |=> $stable(flags_r))
    else $error("flags changed without an update");
  c_chain_zero: cover property (
    alu.upd && alu.z_chain && alu.aff[CSF_BIT_ZERO]);
endmodule
`default_nettype wire

// >>> hw/csf_cpu_status_flags.sv
// CPU status word bits 13 to 0 with priority and saturation control.
//
// How it works
// - Bits 7 to 5 give priority 0 to 7, and 7 masks user interrupts.
// - The core control bit joins above those bits to form a 4-bit level.
// - With the fourth priority bit set all user interrupts are masked.
// - Bits 7 to 5 ignore software writes while nesting is disabled; the fourth bit does not.
// - Bit 4 shows 1 while a repeat loop runs and 0 otherwise.
// - Bit 3 is set by a negative result, cleared by a non-negative one.
// - Bit 2 is set by a signed overflow that flips the sign, else cleared.
// - Bit 1 clears on a non-zero result; set, it means an earlier zero.
// - Bit 0 shows a carry out of the top result bit and doubles as borrow.
// - Writes load the saturation flags or clear them via the combined flag.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module csf_cpu_status_flags (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [csf_pkg::CSF_ADDR_W-1:0] reg_addr_i,
  input wire logic [csf_pkg::CSF_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [csf_pkg::CSF_DATA_W-1:0] reg_rdata_o,
  input wire logic alu_upd_i,
  input wire logic [csf_pkg::CSF_NFLAGS-1:0] alu_affect_i,
  input wire logic alu_neg_i,
  input wire logic alu_ovf_i,
  input wire logic alu_zero_i,
  input wire logic alu_carry_i,
  input wire logic alu_z_chain_i,
  input wire logic loop_busy_i,
  input wire logic ipl_load_i,
  input wire logic [2:0] ipl_value_i,
  input wire logic sat_a_set_i,
  input wire logic sat_b_set_i,
  output logic [3:0] cpu_priority_o,
  output logic user_irq_masked_o,
  output logic loop_active_o,
  output logic [csf_pkg::CSF_NFLAGS-1:0] alu_flags_o,
  output logic acc_a_saturated_o,
  output logic acc_b_saturated_o,
  output logic combined_saturation_flag_o
);
  import csf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic wr_status;
  logic wr_core_ctrl;
  logic wr_int_ctrl;

  assign wr_status = reg_we_i && (reg_addr_i == CSF_OFS_STATUS);
  assign wr_core_ctrl = reg_we_i && (reg_addr_i == CSF_OFS_CORE_CTRL);
  assign wr_int_ctrl = reg_we_i && (reg_addr_i == CSF_OFS_INT_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Priority level and control bits.
  logic [2:0] priority_level_low_r;
  logic [2:0] priority_level_low_nxt;
  logic priority_level_top_r;
  logic priority_level_top_nxt;
  logic nesting_disable_r;
  logic nesting_disable_nxt;

  always_comb begin
    priority_level_low_nxt = priority_level_low_r;
    priority_level_top_nxt = priority_level_top_r;
    nesting_disable_nxt = nesting_disable_r;
    // The interrupt controller loads the level on entry and return and
    // must never lose to software, so its load takes priority.
    if (ipl_load_i) begin
      priority_level_low_nxt = ipl_value_i;
    end else if (wr_status && !nesting_disable_r) begin
      priority_level_low_nxt =
        reg_wdata_i[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO];
    end
    if (wr_core_ctrl) begin
      priority_level_top_nxt = reg_wdata_i[CSF_BIT_PRIO_TOP];
    end
    if (wr_int_ctrl) begin
      nesting_disable_nxt = reg_wdata_i[CSF_BIT_NEST_DIS];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      priority_level_low_r <= CSF_RST_PRIO_LOW;
      priority_level_top_r <= CSF_RST_PRIO_TOP;
      nesting_disable_r <= CSF_RST_NEST_DIS;
    end else begin
      priority_level_low_r <= priority_level_low_nxt;
      priority_level_top_r <= priority_level_top_nxt;
      nesting_disable_r <= nesting_disable_nxt;
    end
  end

  assign cpu_priority_o =
    {priority_level_top_r, priority_level_low_r};
  assign user_irq_masked_o = priority_level_top_r ||
    (priority_level_low_r == CSF_PRIO_MASK_ALL);

  ////////////////////////////////////////////////////////////////////////////
  // Repeat loop indication; the sequencer runs on this clock.
  logic loop_active_flag_r;
  logic loop_active_flag_nxt;

  always_comb begin
    loop_active_flag_nxt = loop_busy_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      loop_active_flag_r <= CSF_RST_LOOP;
    end else begin
      loop_active_flag_r <= loop_active_flag_nxt;
    end
  end

  assign loop_active_o = loop_active_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator saturation flags.
  logic acc_a_saturated_r;
  logic acc_a_saturated_nxt;
  logic acc_b_saturated_r;
  logic acc_b_saturated_nxt;

  // A write with the combined flag at zero clears both flags; otherwise the
  // written bits land directly. A hardware set in the same cycle still wins,
  // which is why bit operations on these flags can lose a saturation event.
  always_comb begin
    acc_a_saturated_nxt = acc_a_saturated_r;
    acc_b_saturated_nxt = acc_b_saturated_r;
    if (wr_status) begin
      if (!reg_wdata_i[CSF_BIT_SAT_ANY]) begin
        acc_a_saturated_nxt = 1'b0;
        acc_b_saturated_nxt = 1'b0;
      end else begin
        acc_a_saturated_nxt = reg_wdata_i[CSF_BIT_SAT_A];
        acc_b_saturated_nxt = reg_wdata_i[CSF_BIT_SAT_B];
      end
    end
    if (sat_a_set_i) begin
      acc_a_saturated_nxt = 1'b1;
    end
    if (sat_b_set_i) begin
      acc_b_saturated_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      acc_a_saturated_r <= CSF_RST_SAT;
      acc_b_saturated_r <= CSF_RST_SAT;
    end else begin
      acc_a_saturated_r <= acc_a_saturated_nxt;
      acc_b_saturated_r <= acc_b_saturated_nxt;
    end
  end

  assign acc_a_saturated_o = acc_a_saturated_r;
  assign acc_b_saturated_o = acc_b_saturated_r;
  assign combined_saturation_flag_o = acc_a_saturated_r | acc_b_saturated_r;

  ////////////////////////////////////////////////////////////////////////////
  // ALU flag unit.
  csf_alu_if alu_bus ();

  assign alu_bus.upd = alu_upd_i;
  assign alu_bus.aff = alu_affect_i;
  assign alu_bus.neg = alu_neg_i;
  assign alu_bus.ovf = alu_ovf_i;
  assign alu_bus.zero = alu_zero_i;
  assign alu_bus.carry = alu_carry_i;
  assign alu_bus.z_chain = alu_z_chain_i;
  assign alu_bus.sw_we = wr_status;
  assign alu_bus.sw_flags = reg_wdata_i[CSF_NFLAGS-1:0];

  csf_alu_flags u_flags (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .alu(alu_bus.unit)
  );

  assign alu_flags_o = alu_bus.flags;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand for exactly the cycle after the strobe.
  logic [CSF_DATA_W-1:0] status_word;
  logic [CSF_DATA_W-1:0] rd_mux;
  logic [CSF_DATA_W-1:0] rdata_r;
  logic [CSF_DATA_W-1:0] rdata_nxt;

  always_comb begin
    status_word = '0;
    status_word[CSF_BIT_SAT_A] = acc_a_saturated_r;
    status_word[CSF_BIT_SAT_B] = acc_b_saturated_r;
    status_word[CSF_BIT_SAT_ANY] = acc_a_saturated_r | acc_b_saturated_r;
    status_word[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO] = priority_level_low_r;
    status_word[CSF_BIT_LOOP] = loop_active_flag_r;
    status_word[CSF_NFLAGS-1:0] = alu_bus.flags;
  end

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      CSF_OFS_STATUS: begin
        rd_mux = status_word;
      end
      CSF_OFS_CORE_CTRL: begin
        rd_mux[CSF_BIT_PRIO_TOP] = priority_level_top_r;
      end
      CSF_OFS_INT_CTRL: begin
        rd_mux[CSF_BIT_NEST_DIS] = nesting_disable_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    rdata_nxt = reg_re_i ? rd_mux : CSF_RST_RDATA;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_r <= CSF_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_prio_sw_write: assert property (
    wr_status && !nesting_disable_r && !ipl_load_i
    |=> cpu_priority_o[2:0] ==
        $past(reg_wdata_i[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO]))
    else $error("priority field did not take the software write");

  a_prio_top_join: assert property (
    wr_core_ctrl ##1 !wr_core_ctrl
    |-> cpu_priority_o[3] == $past(reg_wdata_i[CSF_BIT_PRIO_TOP]))
    else $error("top priority bit not joined above the low bits");

  a_top_masks_all: assert property (
    cpu_priority_o[3] |-> user_irq_masked_o)
    else $error("user interrupts not masked with the top bit set");

  a_seven_masks: assert property (
    !cpu_priority_o[3] |-> user_irq_masked_o == (cpu_priority_o[2:0] == 3'h7))
    else $error("masking wrong for the low priority level");

  a_prio_locked: assert property (
    wr_status && nesting_disable_r && !ipl_load_i
    |=> $stable(cpu_priority_o[2:0]))
    else $error("priority field written while nesting is disabled");

  a_loop_follows: assert property (
    loop_busy_i [*2] |-> ##1 loop_active_o && $past(loop_active_o))
    else $error("loop active bit does not follow the sequencer");

  a_loop_reads: assert property (
    reg_re_i && reg_addr_i == CSF_OFS_STATUS
    |=> reg_rdata_o[CSF_BIT_LOOP] == $past(loop_active_o))
    else $error("loop active bit reads wrong");

  a_sat_clear: assert property (
    wr_status && !reg_wdata_i[CSF_BIT_SAT_ANY] && !sat_a_set_i && !sat_b_set_i
    |=> !acc_a_saturated_o && !acc_b_saturated_o
        && !combined_saturation_flag_o)
    else $error("clearing the combined flag left a saturation flag set");

  a_sat_direct: assert property (
    wr_status && reg_wdata_i[CSF_BIT_SAT_ANY] && !sat_a_set_i
    |=> acc_a_saturated_o == $past(reg_wdata_i[CSF_BIT_SAT_A]))
    else $error("direct write to saturation flag lost");

  a_sat_set_wins: assert property (
    sat_a_set_i || sat_b_set_i |=> combined_saturation_flag_o)
    else $error("hardware saturation event lost");

  a_rdata_idle: assert property (
    !reg_re_i |=> reg_rdata_o == 16'h0000)
    else $error("read data present without a read");

  c_prio_locked_write: cover property (wr_status && nesting_disable_r);
  c_top_level: cover property (wr_core_ctrl ##1 cpu_priority_o[3]);
  c_sat_clear: cover property (
    combined_saturation_flag_o ##1 wr_status ##1 !combined_saturation_flag_o);
  c_loop_read: cover property (
    loop_active_o && reg_re_i && reg_addr_i == CSF_OFS_STATUS);
endmodule
`default_nettype wire

// >>> verif/csf_core_model.sv
// Behavioural core model: an adder that reports its result flags.
`timescale 1ns/1ps
`default_nettype none
module csf_core_model (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic op_req_i,
  input wire logic [15:0] op_a_i,
  input wire logic [15:0] op_b_i,
  input wire logic [3:0] op_aff_i,
  input wire logic op_chain_i,
  output logic alu_upd_o,
  output logic [3:0] alu_affect_o,
  output logic alu_neg_o,
  output logic alu_ovf_o,
  output logic alu_zero_o,
  output logic alu_carry_o,
  output logic alu_z_chain_o
);
  logic [16:0] sum;
  assign sum = {1'b0, op_a_i} + {1'b0, op_b_i};
  ////////////////////////////////////////////////////////////////////////////
  // Result lines change every cycle outside an update, so a flag that
  // samples them without a strobe shows up at once.
  always @(posedge mclk_i) begin
    alu_upd_o <= op_req_i && !sys_rst_i;
    if (sys_rst_i) begin
      {alu_affect_o, alu_neg_o, alu_ovf_o} <= 6'h00;
      {alu_zero_o, alu_carry_o, alu_z_chain_o} <= 3'h0;
    end else if (op_req_i) begin
      alu_affect_o <= op_aff_i;
      alu_neg_o <= sum[15];
      alu_ovf_o <= op_a_i[15] == op_b_i[15] && sum[15] != op_a_i[15];
      alu_zero_o <= sum[15:0] == 16'h0000;
      alu_carry_o <= sum[16];
      alu_z_chain_o <= op_chain_i;
    end else begin
      alu_affect_o <= ~alu_affect_o;
      {alu_neg_o, alu_ovf_o} <= ~{alu_neg_o, alu_ovf_o};
      {alu_zero_o, alu_carry_o} <= ~{alu_zero_o, alu_carry_o};
      alu_z_chain_o <= ~alu_z_chain_o;
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_cpu_status_flags.sv
// Self-checking bench for the CPU status flag block.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_status_flags;
  import csf_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] rdata;
  logic op_req = 1'b0;
  logic op_chain = 1'b0;
  logic [15:0] op_a = 16'h0000;
  logic [15:0] op_b = 16'h0000;
  logic [3:0] op_aff = 4'h0;
  logic upd, neg, ovf, zero, carry, zch;
  logic [3:0] aff;
  logic loop_busy = 1'b0;
  logic ipl_load = 1'b0;
  logic [2:0] ipl_value = 3'h0;
  logic sat_a = 1'b0;
  logic sat_b = 1'b0;
  logic [3:0] prio, flags;
  logic masked, loop_act, sa, sb, combined_saturation_flag;
  logic [3:0] e_flags = 4'h0;
  logic [2:0] e_prio = 3'h0;
  logic e_top = 1'b0;
  logic e_nest = 1'b0;
  logic e_loop = 1'b0;
  logic e_sa = 1'b0;
  logic e_sb = 1'b0;
  int checks = 0;
  int num_errors = 0;
  int i;
  logic [15:0] d;

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  csf_core_model u_csf_core_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .op_req_i(op_req), .op_a_i(op_a), .op_b_i(op_b), .op_aff_i(op_aff),
    .op_chain_i(op_chain), .alu_upd_o(upd), .alu_affect_o(aff),
    .alu_neg_o(neg), .alu_ovf_o(ovf), .alu_zero_o(zero),
    .alu_carry_o(carry), .alu_z_chain_o(zch));

  csf_cpu_status_flags u_csf_cpu_status_flags (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .alu_upd_i(upd),
    .alu_affect_i(aff), .alu_neg_i(neg), .alu_ovf_i(ovf),
    .alu_zero_i(zero), .alu_carry_i(carry), .alu_z_chain_i(zch),
    .loop_busy_i(loop_busy), .ipl_load_i(ipl_load),
    .ipl_value_i(ipl_value), .sat_a_set_i(sat_a), .sat_b_set_i(sat_b),
    .cpu_priority_o(prio), .user_irq_masked_o(masked),
    .loop_active_o(loop_act), .alu_flags_o(flags),
    .acc_a_saturated_o(sa), .acc_b_saturated_o(sb),
    .combined_saturation_flag_o(combined_saturation_flag));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [15:0] status_word();
    return {2'h0, e_sa, e_sb, 1'b0, e_sa | e_sb, 2'h0, e_prio, e_loop,
            e_flags};
  endfunction

  // Only flags named in the affect mask take the new result.
  function automatic logic [3:0] exp_flags(input logic [15:0] a, b,
                                           input logic [3:0] m,
                                           input logic ch);
    logic [16:0] s;
    logic [3:0] r;
    s = {1'b0, a} + {1'b0, b};
    r = {s[15], a[15] == b[15] && s[15] != a[15], s[15:0] == 16'h0, s[16]};
    if (ch) begin
      r[1] = r[1] & e_flags[1];
    end
    return (r & m) | (e_flags & ~m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge mclk_i);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask

  // Whole-word writes only, so the saturation flags never see a bit op.
  task automatic wr_status(input logic [15:0] v);
    wr(CSF_OFS_STATUS, v);
    if (!e_nest) begin
      e_prio = v[7:5];
    end
    e_flags = v[3:0];
    {e_sa, e_sb} = v[10] ? v[13:12] : 2'b00;
  endtask

  task automatic check_all();
    logic [15:0] v;
    check("priority", {12'h0, prio}, {12'h0, e_top, e_prio});
    check("masked", {15'h0, masked},
          {15'h0, e_top | (e_prio == 3'h7)});
    check("loop", {15'h0, loop_act}, {15'h0, e_loop});
    check("flags", {12'h0, flags}, {12'h0, e_flags});
    check("sat", {13'h0, sa, sb, combined_saturation_flag},
          {13'h0, e_sa, e_sb, e_sa | e_sb});
    rd(CSF_OFS_STATUS, v);
    check("status", v, status_word());
    rd(CSF_OFS_CORE_CTRL, v);
    check("core ctrl", v, {12'h0, e_top, 3'h0});
    rd(CSF_OFS_INT_CTRL, v);
    check("int ctrl", v, {e_nest, 15'h0});
  endtask

  task automatic alu_op(input logic [15:0] a, b, input logic [3:0] m,
                        input logic ch);
    @(posedge mclk_i);
    op_req <= 1'b1;
    {op_a, op_b, op_aff, op_chain} <= {a, b, m, ch};
    @(posedge mclk_i);
    op_req <= 1'b0;
    @(posedge mclk_i);
    #1 e_flags = exp_flags(a, b, m, ch);
    check("alu", {12'h0, flags}, {12'h0, e_flags});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    num_errors = num_errors + 1;
    complete_run();
  end

  initial begin
    void'($urandom(41));
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    #1 check_all();
    for (i = 0; i < 16; i++) begin
      wr(CSF_OFS_CORE_CTRL, {12'h0, i[3], 3'h0});
      e_top = i[3];
      wr_status({8'h00, i[2:0], 1'b0, 4'($urandom)});
      check_all();
    end
    wr(CSF_OFS_INT_CTRL, 16'h8000);
    e_nest = 1'b1;
    wr_status(16'h0045);
    check_all();
    @(posedge mclk_i);
    ipl_load <= 1'b1;
    ipl_value <= 3'h5;
    @(posedge mclk_i);
    ipl_load <= 1'b0;
    #1 e_prio = 3'h5;
    check_all();
    wr(CSF_OFS_INT_CTRL, 16'h0000);
    e_nest = 1'b0;
    wr_status(16'h00c0);
    check_all();
    @(posedge mclk_i);
    loop_busy <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 e_loop = 1'b1;
    check_all();
    @(posedge mclk_i);
    loop_busy <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 e_loop = 1'b0;
    check_all();
    wr_status(16'h2400);
    check_all();
    wr_status(16'h3400);
    check_all();
    wr_status(16'h3000);
    check_all();
    @(posedge mclk_i);
    sat_b <= 1'b1;
    @(posedge mclk_i);
    sat_b <= 1'b0;
    #1 e_sb = 1'b1;
    check_all();
    rd(4'hf, d);
    check("unmapped", d, 16'h0000);
    @(posedge mclk_i);
    #1 check("rdata idle", rdata, 16'h0000);
    alu_op(16'h8000, 16'h8000, 4'hf, 1'b0);
    alu_op(16'h7fff, 16'h0001, 4'hf, 1'b0);
    alu_op(16'h0001, 16'h0001, 4'hf, 1'b1);
    alu_op(16'hffff, 16'h0001, 4'h5, 1'b0);
    alu_op(16'h0000, 16'h0000, 4'h2, 1'b1);
    repeat (300) begin
      alu_op(16'($urandom), 16'($urandom), 4'($urandom),
             1'($urandom % 4 == 0));
    end
    check_all();
    // A reset in mid-run must bring every register back to zero.
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    {e_flags, e_prio, e_top, e_nest, e_sa, e_sb} = 11'h000;
    @(posedge mclk_i);
    #1 check_all();
    complete_run();
  end
endmodule
`default_nettype wire
